//--- logic/sdcd_consts.svh
`ifndef SDCD_CONSTS_SVH
`define SDCD_CONSTS_SVH

// Address bit that asks for auto-precharge or precharge of all banks
`define SDCD_AP_BIT      10
// Burst length field of the mode word
`define SDCD_BL_MSB      2
`define SDCD_BL_LSB      0
`define SDCD_BL_ONE      3'h0
`define SDCD_BL_TWO      3'h1
`define SDCD_BL_FOUR     3'h2
`define SDCD_BL_EIGHT    3'h3
`define SDCD_BL_FULL     3'h7
// Column counter width and last-beat counts
`define SDCD_COL_MSB     8
`define SDCD_LEFT_ONE    9'h000
`define SDCD_LEFT_TWO    9'h001
`define SDCD_LEFT_FOUR   9'h003
`define SDCD_LEFT_EIGHT  9'h007
`define SDCD_LEFT_FULL   9'h1ff
// Reset values
`define SDCD_RST_BL      3'h0
`define SDCD_RST_BANKS   4'h0
`define SDCD_RST_COL     9'h000
`define SDCD_RST_WORD    16'h0000

`endif

//--- logic/sdcd_pkg.sv
package sdcd_pkg;

	typedef enum logic [3:0] {
		CMD_DESEL,
		CMD_NOP,
		CMD_ACT,
		CMD_READ,
		CMD_WRITE,
		CMD_PRE,
		CMD_MRS,
		CMD_BST,
		CMD_REF
	} sdcd_cmd_t;

	typedef enum logic [1:0] {
		PW_RUN,
		PW_SUSPEND,
		PW_PDOWN,
		PW_SELF
	} sdcd_pwr_t;

endpackage

//--- logic/sdcd_decode.sv
`include "sdcd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sdcd_decode
	import sdcd_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic        bank_select_lo,
	input  wire logic        bank_select_hi,
	input  wire logic [11:0] addr,
	input  wire logic        dqm,
	input  wire logic [15:0] rd_word,
	output var  sdcd_cmd_t   cmd_q,
	output logic             cmd_stb_q,
	output logic [1:0]       cmd_bank_q,
	output logic             cmd_apre_q,
	output logic             cmd_err_q,
	output var  sdcd_pwr_t   pwr_q,
	output logic             rx_en_q,
	output logic [3:0]       bank_open_q,
	output logic [2:0]       mode_bl_q,
	output logic             burst_run_q,
	output logic             burst_rd_q,
	output logic [8:0]       burst_col_q,
	output logic [8:0]       burst_left_q,
	output logic [15:0]      dout_q,
	output logic             dout_en_q
);

	function automatic sdcd_cmd_t strobe_dec(input logic r, input logic c,
			input logic w);
		unique case ({r, c, w})
			3'b011:  strobe_dec = CMD_ACT;
			3'b101:  strobe_dec = CMD_READ;
			3'b100:  strobe_dec = CMD_WRITE;
			3'b010:  strobe_dec = CMD_PRE;
			3'b000:  strobe_dec = CMD_MRS;
			3'b110:  strobe_dec = CMD_BST;
			3'b001:  strobe_dec = CMD_REF;
			default: strobe_dec = CMD_NOP;
		endcase
	endfunction

	function automatic logic [8:0] last_beat(input logic [2:0] bl);
		unique case (bl)
			`SDCD_BL_TWO:   last_beat = `SDCD_LEFT_TWO;
			`SDCD_BL_FOUR:  last_beat = `SDCD_LEFT_FOUR;
			`SDCD_BL_EIGHT: last_beat = `SDCD_LEFT_EIGHT;
			`SDCD_BL_FULL:  last_beat = `SDCD_LEFT_FULL;
			default:        last_beat = `SDCD_LEFT_ONE;
		endcase
	endfunction

	logic       cke_prev_q;
	logic       dqm_q;
	logic       burst_apre_q;
	logic [1:0] burst_bank_q;
	sdcd_cmd_t  cmd_raw;
	logic [1:0] bank;
	logic       live;
	logic       legal;
	logic       take;
	logic       cke_fall;
	logic       cke_rise;
	logic       run_ok;
	logic       full_page;
	logic       burst_end;

	always_comb begin
		bank     = {bank_select_hi, bank_select_lo};
		cmd_raw  = cs_n ? CMD_DESEL : strobe_dec(ras_n, cas_n, we_n);
		live     = (pwr_q == PW_RUN) && cke_prev_q;
		cke_fall = cke_prev_q && !cke;
		cke_rise = !cke_prev_q && cke;
		run_ok   = (pwr_q == PW_RUN);
		full_page = (mode_bl_q == `SDCD_BL_FULL);
		burst_end = run_ok && burst_run_q && !full_page
			&& (burst_left_q == `SDCD_RST_COL);
	end

	always_comb begin
		unique case (cmd_raw)
			CMD_ACT:   legal = !bank_open_q[bank];
			CMD_READ,
			CMD_WRITE: legal = bank_open_q[bank];
			CMD_BST:   legal = burst_run_q && full_page;
			CMD_MRS:   legal = (bank_open_q == `SDCD_RST_BANKS);
			CMD_REF:   legal = cke && (bank_open_q == `SDCD_RST_BANKS);
			default:   legal = 1'b1;
		endcase
		take = live && legal;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cke_prev_q <= 1'b0;
		end else begin
			cke_prev_q <= cke;
		end
	end

	// Power state; receivers stay on only while running or suspended
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwr_q   <= PW_RUN;
			rx_en_q <= 1'b1;
		end else begin
			unique case (pwr_q)
				PW_RUN: begin
					if (cke_fall) begin
						if ((|bank_open_q) || burst_run_q) begin
							pwr_q   <= PW_SUSPEND;
						end else if (cmd_raw == CMD_REF) begin
							pwr_q   <= PW_SELF;
							rx_en_q <= 1'b0;
						end else begin
							pwr_q   <= PW_PDOWN;
							rx_en_q <= 1'b0;
						end
					end
				end
				PW_SUSPEND: begin
					if (cke_rise) begin
						pwr_q <= PW_RUN;
					end
				end
				PW_PDOWN, PW_SELF: begin
					if (cke_rise) begin
						pwr_q   <= PW_RUN;
						rx_en_q <= 1'b1;
					end
				end
			endcase
		end
	end

	// Decoded command report, one cycle per sampled edge
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmd_q      <= CMD_NOP;
			cmd_stb_q  <= 1'b0;
			cmd_bank_q <= 2'h0;
			cmd_apre_q <= 1'b0;
			cmd_err_q  <= 1'b0;
		end else begin
			cmd_q      <= live ? cmd_raw : CMD_NOP;
			cmd_stb_q  <= take && (cmd_raw != CMD_NOP)
				&& (cmd_raw != CMD_DESEL);
			cmd_bank_q <= bank;
			cmd_apre_q <= addr[`SDCD_AP_BIT];
			cmd_err_q  <= live && !legal;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_bl_q <= `SDCD_RST_BL;
		end else if (take && cmd_raw == CMD_MRS) begin
			mode_bl_q <= addr[`SDCD_BL_MSB:`SDCD_BL_LSB];
		end
	end

	// Bank open flags; auto-precharge closes the bank at burst end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bank_open_q <= `SDCD_RST_BANKS;
		end else begin
			if (burst_end && burst_apre_q) begin
				bank_open_q[burst_bank_q] <= 1'b0;
			end
			if (take && cmd_raw == CMD_ACT) begin
				bank_open_q[bank] <= 1'b1;
			end else if (take && cmd_raw == CMD_PRE) begin
				if (addr[`SDCD_AP_BIT]) begin
					bank_open_q <= `SDCD_RST_BANKS;
				end else begin
					bank_open_q[bank] <= 1'b0;
				end
			end
		end
	end

	// Burst tracking; frozen outside the run state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			burst_run_q  <= 1'b0;
			burst_rd_q   <= 1'b0;
			burst_apre_q <= 1'b0;
			burst_bank_q <= 2'h0;
			burst_col_q  <= `SDCD_RST_COL;
			burst_left_q <= `SDCD_RST_COL;
		end else if (take && (cmd_raw == CMD_READ
				|| cmd_raw == CMD_WRITE)) begin
			burst_run_q  <= 1'b1;
			burst_rd_q   <= (cmd_raw == CMD_READ);
			burst_apre_q <= addr[`SDCD_AP_BIT] && !full_page;
			burst_bank_q <= bank;
			burst_col_q  <= addr[`SDCD_COL_MSB:0];
			burst_left_q <= last_beat(mode_bl_q);
		end else if (take && cmd_raw == CMD_BST) begin
			burst_run_q <= 1'b0;
		end else if (take && cmd_raw == CMD_PRE
				&& (addr[`SDCD_AP_BIT] || bank == burst_bank_q)) begin
			burst_run_q <= 1'b0;
		end else if (run_ok && burst_run_q) begin
			burst_col_q <= burst_col_q + 9'h001;
			if (burst_end) begin
				burst_run_q <= 1'b0;
			end else if (!full_page) begin
				burst_left_q <= burst_left_q - 9'h001;
			end
		end
	end

	// Output data latch and byte mask
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dqm_q     <= 1'b0;
			dout_q    <= `SDCD_RST_WORD;
			dout_en_q <= 1'b0;
		end else if (run_ok) begin
			if (cke_prev_q) begin
				dqm_q <= dqm;
			end
			if (burst_run_q && burst_rd_q) begin
				dout_q <= rd_word;
			end
			dout_en_q <= burst_run_q && burst_rd_q && !dqm_q;
		end
	end

endmodule // sdcd_decode

`default_nettype wire

//--- tb/sdcd_decode_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sdcd_chk
	import sdcd_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       cke,
	input wire logic       cs_n,
	input wire logic       ras_n,
	input wire logic       cas_n,
	input wire logic       we_n,
	input var  sdcd_cmd_t  cmd_q,
	input wire logic       cmd_stb_q,
	input wire logic       cmd_err_q,
	input var  sdcd_pwr_t  pwr_q,
	input wire logic       rx_en_q,
	input wire logic [3:0] bank_open_q,
	input wire logic       burst_run_q,
	input wire logic [8:0] burst_col_q,
	input wire logic [8:0] burst_left_q
);
	localparam sdcd_cmd_t CT[8] = '{CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT,
		CMD_WRITE, CMD_READ, CMD_BST, CMD_NOP};
	logic ckp_q;
	wire logic live = ckp_q && pwr_q == PW_RUN;
	wire logic [2:0] code = {ras_n, cas_n, we_n};
	always_ff @(posedge ref_clk) ckp_q <= rst ? 1'b0 : cke;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_desel; live && cs_n |=> !cmd_stb_q && !cmd_err_q; endproperty
	a_desel: assert property (p_desel) else $error("desel taken");
	property p_dec; live && cke && !cs_n |=> cmd_q == CT[$past(code)];
	endproperty
	a_dec: assert property (p_dec) else $error("bad decode");
	property p_dead; !live |=> cmd_q == CMD_NOP && !cmd_stb_q && !cmd_err_q;
	endproperty
	a_dead: assert property (p_dead) else $error("dead cmd");
	property p_pdn; live && !cke && bank_open_q == 4'h0 && !burst_run_q |=>
		!rx_en_q && pwr_q == (!$past(cs_n) && $past(code) == 3'h1 ?
		PW_SELF : PW_PDOWN); endproperty
	a_pdn: assert property (p_pdn) else $error("no pdown");
	property p_susp; live && !cke && (bank_open_q != 4'h0 || burst_run_q)
		|=> pwr_q == PW_SUSPEND; endproperty
	a_susp: assert property (p_susp) else $error("no susp");
	property p_hold; pwr_q == PW_SUSPEND |=> $stable(burst_col_q) &&
		$stable(burst_left_q); endproperty
	a_hold: assert property (p_hold) else $error("burst moved");
	property p_wake; pwr_q != PW_RUN && cke |=> pwr_q == PW_RUN && rx_en_q;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_keep; burst_run_q && burst_left_q != 9'h000 &&
		(cs_n || code == 3'h7) |=> burst_run_q; endproperty
	a_keep: assert property (p_keep) else $error("burst cut");
	c_susp: cover property (pwr_q == PW_SUSPEND);
	c_pdn: cover property (pwr_q == PW_PDOWN);
	c_self: cover property (pwr_q == PW_SELF);
endmodule // sdcd_chk
`default_nettype wire

//--- tb/sdcd_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module sdcd_ctl (
	input  wire logic        ref_clk,
	output var  logic        cke,
	output var  logic        cs_n,
	output var  logic        ras_n,
	output var  logic        cas_n,
	output var  logic        we_n,
	output var  logic        bank_select_lo,
	output var  logic        bank_select_hi,
	output var  logic [11:0] addr,
	output var  logic        dqm
);
	initial {cke, cs_n, ras_n, cas_n, we_n, dqm} = 6'h1e;
	initial {bank_select_hi, bank_select_lo, addr} = 14'h0000;
	task automatic go(input logic k, input logic [3:0] c,
		input logic [1:0] b, input logic [11:0] a);
		@(posedge ref_clk);
		if (k && !cke) c = 4'h7;
		{cke, cs_n, ras_n, cas_n, we_n} <= {k, c};
		{bank_select_hi, bank_select_lo, addr} <= {b, a};
	endtask
endmodule // sdcd_ctl
`default_nettype wire

//--- tb/sdram_cmd_decode_power_states_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_decode_power_states_bench
	import sdcd_pkg::*;
;
	localparam sdcd_cmd_t CT[8] = '{CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT,
		CMD_WRITE, CMD_READ, CMD_BST, CMD_NOP};
	typedef struct packed {logic [3:0] c; logic s, e, k;
		logic [1:0] p; logic [3:0] o; logic r, n; logic [2:0] m;
		logic [1:0] b;} sdcd_exp_t;
	logic ref_clk = 1'b0, rst = 1'b1;
	logic cke, cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi, dqm;
	logic [11:0] addr;
	logic [15:0] rd_word = 16'h0000, dout_q;
	sdcd_cmd_t cmd_q;
	sdcd_pwr_t pwr_q;
	logic cmd_stb_q, cmd_apre_q, cmd_err_q, rx_en_q, dout_en_q;
	logic burst_run_q, burst_rd_q;
	logic [1:0] cmd_bank_q;
	logic [3:0] bank_open_q;
	logic [2:0] mode_bl_q;
	logic [8:0] burst_col_q, burst_left_q;
	logic [31:0] lf = 32'h0ab3;
	int err_count = 0, n_checks = 0, cyc = 0, bk;
	int pw = 0, ckp = 0, op = 0, run = 0, lft = 0, bb = 0, bl = 0;
	sdcd_exp_t q[$];
	sdcd_decode sdcd_decode_i (.*);
	sdcd_ctl sdcd_ctl_i (.*);
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		lf <= nx(lf);
		rd_word <= lf[15:0];
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [3:0] s, e);
		n_checks++;
		if (s !== e) begin
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
			err_count++;
		end
	endtask
	task automatic st(input logic k, input logic [3:0] c, input int b, a);
		sdcd_exp_t x;
		int po;
		logic lv, g;
		sdcd_ctl_i.go(k, c, 2'(b), 12'(a));
		#1;
		if (q.size() > 0) begin
			x = q.pop_front();
			if (x.k) chk("cmd", cmd_q, x.c);
			if (x.k) chk("stb", 4'(cmd_stb_q), 4'(x.s));
			if (x.k) chk("err", 4'(cmd_err_q), 4'(x.e));
			chk("pwr", 4'(pwr_q), 4'(x.p));
			chk("open", bank_open_q, x.o);
			chk("run", 4'(burst_run_q), 4'(x.r));
			chk("rx", 4'(rx_en_q), 4'(x.n));
			chk("bl", 4'(mode_bl_q), 4'(x.m));
			chk("bank", 4'(cmd_bank_q), 4'(x.b));
		end
		b = {bank_select_hi, bank_select_lo};
		po = pw;
		lv = pw == 0 && ckp;
		x = '0;
		x.c = lv ? (cs_n ? CMD_DESEL : CT[{ras_n, cas_n, we_n}]) : CMD_NOP;
		x.k = !(lv && !cke);
		case (x.c)
			CMD_ACT: g = !op[b];
			CMD_READ, CMD_WRITE: g = op[b];
			CMD_BST: g = run && bl == 7;
			CMD_MRS, CMD_REF: g = op == 0 && !run;
			default: g = 1;
		endcase
		x.s = g && x.c > CMD_NOP;
		x.e = !g;
		if (lv && !cke)
			pw = (op || run) ? 1 : (!cs_n && x.c == CMD_REF) ? 3 : 2;
		else if (pw != 0 && cke)
			pw = 0;
		if (po != 1 && run) begin
			run = lft != 0;
			lft--;
		end
		if (x.s) case (x.c)
			CMD_ACT: op[b] = 1;
			CMD_PRE: begin
				run = run && !addr[10] && b != bb;
				op = addr[10] ? 0 : op & ~(1 << b);
			end
			CMD_MRS: bl = addr[2:0];
			CMD_READ, CMD_WRITE: begin
				run = 1;
				lft = (1 << bl) - 1;
				bb = b;
			end
			default: ;
		endcase
		x.p = 2'(pw);
		x.o = 4'(op);
		x.r = run != 0;
		x.n = pw < 2;
		x.m = 3'(bl);
		x.b = 2'(b);
		ckp = cke;
		q.push_back(x);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		bk = lf[1:0];
		repeat (2) st(1, 4'h7, 0, 0);
		st(1, 4'h0, 0, 2);
		st(1, 4'h1, 0, 0);
		repeat (2) st(1, 4'h3, bk, 0);
		st(1, 4'h4, bk ^ 1, 0);
		st(1, 4'h6, bk, 0);
		st(1, 4'h5, bk, 0);
		st(1, {1'b1, lf[2:0]}, bk, 0);
		st(0, 4'h7, 0, 0);
		st(0, 4'h5, bk, 0);
		repeat (4) st(1, 4'h7, 0, 0);
		st(1, 4'h4, bk, 0);
		st(1, 4'h2, 0, 1024);
		repeat (2) st(0, 4'h7, 0, 0);
		repeat (2) st(1, 4'h7, 0, 0);
		st(0, 4'h1, 0, 0);
		st(0, 4'h7, 0, 0);
		repeat (3) st(1, 4'h7, 0, 0);
		end_of_test();
	end
endmodule // sdram_cmd_decode_power_states_bench
bind sdcd_decode sdcd_chk sdcd_chk_i (.*);
`default_nettype wire
